// ==== design/sar_pkg.sv ====
// shared constants and types for the secure access remap channel unit
package sar_pkg;
    // ==========================================================
    // configuration bus offsets
    localparam logic [5:0] CTRL_OFF = 6'h00;
    localparam logic [5:0] CONFIG_OFF = 6'h04;
    localparam logic [5:0] CHEN_HI_OFF = 6'h08;
    localparam logic [5:0] CHEN_LO_OFF = 6'h0C;
    localparam logic [5:0] STATUS_OFF = 6'h10;
    localparam logic [5:0] IEN_OFF = 6'h14;
    localparam logic [5:0] IOFF_OFF = 6'h18;
    localparam logic [5:0] IMASK_OFF = 6'h1C;
    localparam logic [5:0] ICLR_OFF = 6'h20;
    // ==========================================================
    // control word bits
    localparam int CTL_ON = 0;
    localparam int CTL_OFF = 1;
    localparam int CTL_SETUP_IN = 2;
    localparam int CTL_SETUP_OUT = 3;
    localparam int CTL_BERR_ON = 4;
    localparam int CTL_BERR_OFF = 5;
    // ==========================================================
    // config word and unlock word fields
    localparam int KEY_W = 8;
    localparam int CYC_W = 8;
    localparam int CFG_KEY_LSB = 0;
    localparam int CFG_CYC_LSB = 8;
    localparam int CFG_OPEN_BIT = 16;
    localparam int UNLK_KEY_LSB = 0;
    localparam int UNLK_CH_LSB = 8;
    // ==========================================================
    // status bits; events 0..7 reach the interrupt
    localparam int EVT_W = 8;
    localparam int ST_ACC_OK = 0;
    localparam int ST_ACC_FAIL = 1;
    localparam int ST_EXPIRED = 2;
    localparam int ST_UNLK_READ = 3;
    localparam int ST_KEY_ERR = 4;
    localparam int ST_UNLK_ERR = 5;
    localparam int ST_MBUS_ERR = 6;
    localparam int ST_RTADR_ERR = 7;
    localparam int ST_ON = 8;
    localparam int ST_SETUP = 9;
    localparam int ST_IDLE = 10;
    localparam logic [7:0] ERR_MASK = 8'hFE;
    localparam logic [31:0] STATUS_RESET = 32'h00000400;
    // ==========================================================
    // channel space
    localparam int NUM_CH = 64;
    localparam int RTR_CH = 63;
    localparam logic [5:0] UNLK_IDX = 6'h3F;
    localparam logic [31:0] REMAP_LOW = 32'hFFFC0000;
    // ==========================================================
    // host command registers (axi4-lite)
    localparam logic [7:0] HOST_CMD_OFF = 8'h00;
    localparam logic [7:0] HOST_WDATA_OFF = 8'h04;
    localparam logic [7:0] HOST_RDATA_OFF = 8'h08;
    localparam logic [7:0] HOST_STAT_OFF = 8'h0C;
    localparam int CMD_FAST_BIT = 8;
    localparam int CMD_WR_BIT = 9;
    localparam int TGT_WORDS = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_MASTER = 2'b10
    } sar_dev_state_e;
endpackage : sar_pkg

// ==== design/sar_if.sv ====
// link between the secure access unit and the cpu / peripheral side
`timescale 1ns/10ps
`default_nettype none
interface sar_if;
    logic cfg_req;
    logic cfg_wr;
    logic [5:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic cfg_done;
    logic hs_req;
    logic hs_wr;
    logic [7:0] hs_addr;
    logic [31:0] hs_wdata;
    logic [31:0] hs_rdata;
    logic hs_done;
    logic hs_err;
    logic m_req;
    logic m_wr;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic [31:0] m_rdata;
    logic m_done;
    logic m_err;
    logic irq;
    modport dev_mp (
        input cfg_req, cfg_wr, cfg_addr, cfg_wdata, hs_req, hs_wr, hs_addr, hs_wdata,
        input m_rdata, m_done, m_err,
        output cfg_rdata, cfg_done, hs_rdata, hs_done, hs_err, m_req, m_wr, m_addr, m_wdata,
        output irq
    );
    modport host_mp (
        output cfg_req, cfg_wr, cfg_addr, cfg_wdata, hs_req, hs_wr, hs_addr, hs_wdata,
        output m_rdata, m_done, m_err,
        input cfg_rdata, cfg_done, hs_rdata, hs_done, hs_err, m_req, m_wr, m_addr, m_wdata,
        input irq
    );
endinterface : sar_if
`default_nettype wire

// ==== design/sar_target.sv ====
// small remapped peripheral register bank answering the unit's master port
`timescale 1ns/10ps
`default_nettype none
module sar_target (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic req,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic done,
    output logic err
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [sar_pkg::TGT_WORDS-1:0][31:0] mem;
        logic [31:0] rdata;
        logic done;
        logic err;
    } sar_tgt_s;
    sar_tgt_s r;
    sar_tgt_s n;
    logic [31:0] offs;
    logic hit;

    assign offs = addr - sar_pkg::REMAP_LOW;
    assign hit = (addr >= sar_pkg::REMAP_LOW) && (offs[31:2] < 30'(sar_pkg::TGT_WORDS));

    always_comb begin
        n = r;
        n.done = 1'b0;
        n.err = 1'b0;
        // one-cycle answer; the done guard stops a held request being taken twice
        if (req && !r.done) begin
            n.done = 1'b1;
            n.err = !hit;
            n.rdata = 32'h00000000;
            if (hit && wr) begin
                n.mem[offs[3:2]] = wdata;
            end else if (hit) begin
                n.rdata = r.mem[offs[3:2]];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign rdata = r.rdata;
    assign done = r.done;
    assign err = r.err;
endmodule : sar_target
`default_nettype wire

// ==== design/sar_device.sv ====
// secure access unit: channel remap, lock mechanism, status and interrupt
// ==========================================================
// Summary of operation
// - enable bit turns unit on, status shows
// - same address: channel normally, target in setup
// - setup entry/exit bits switch mode
// - channel usable only once its enable bit set
// - remap only targets at or above region base
// - low target write flags address error
// - open bit skips unlocking, else locked mode
// - software sets key and window before locked use
// - single unlock write with key and channel
// - window ends on timeout or one access
// - only one channel unlocked at once
// - locked access aborts, flags fail; completion flags success
// - pending error aborts unlock, flags unlock error
// - wrong key flags key error, no unlock
// - reading unlock register flags read error
// - unused window expiry flags expired
// - permitted access reissued at target address
// - idle flag marks completion of channel operation
// - interrupt from event and mask; set/clear registers
// - bus error on three events when enabled
// - master bus error flag on those events
// - software waits idle before disabling unit
// - error response off bit stops bus errors
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sar_device (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    sar_if.dev_mp b
);
    // ==========================================================
    // state
    typedef struct packed {
        sar_pkg::sar_dev_state_e state;
        logic on;
        logic setup;
        logic berr_on;
        logic open;
        logic [sar_pkg::KEY_W-1:0] key;
        logic [sar_pkg::CYC_W-1:0] cyc;
        logic [sar_pkg::NUM_CH-1:0] chen;
        logic [sar_pkg::EVT_W-1:0] evt;
        logic [sar_pkg::EVT_W-1:0] imask;
        logic unlocked;
        logic [5:0] ulch;
        logic [sar_pkg::CYC_W-1:0] timer;
        logic [sar_pkg::RTR_CH:0][31:0] remap_target_reg;
        logic [31:0] cfg_rdata;
        logic cfg_done;
        logic [31:0] hs_rdata;
        logic hs_done;
        logic hs_err;
        logic m_req;
        logic m_wr;
        logic [31:0] m_addr;
        logic [31:0] m_wdata;
    } sar_dev_s;
    sar_dev_s r;
    sar_dev_s n;
    logic [5:0] ch;
    logic [31:0] wd;
    logic [31:0] tgt;
    logic permit;
    logic touch;

    assign ch = b.hs_addr[7:2];
    assign wd = b.cfg_wdata;
    assign tgt = r.remap_target_reg[ch];
    // locked mode needs this exact channel unlocked; open mode skips the unlock check
    assign permit = r.on && r.chen[ch] && (tgt >= sar_pkg::REMAP_LOW)
        && (r.open || (r.unlocked && (r.ulch == ch)));

    always_comb begin
        n = r;
        touch = 1'b0;
        n.cfg_done = 1'b0;
        n.hs_done = 1'b0;
        n.hs_err = 1'b0;
        // ==========================================================
        // configuration port; clears land first so a same-cycle event wins
        if (b.cfg_req && !r.cfg_done) begin
            n.cfg_done = 1'b1;
            n.cfg_rdata = 32'h00000000;
            if (b.cfg_wr) begin
                if (b.cfg_addr == sar_pkg::CTRL_OFF) begin
                    if (wd[sar_pkg::CTL_ON]) begin
                        n.on = 1'b1;
                    end
                    if (wd[sar_pkg::CTL_OFF]) begin
                        n.on = 1'b0;
                    end
                    if (wd[sar_pkg::CTL_SETUP_IN]) begin
                        n.setup = 1'b1;
                    end
                    if (wd[sar_pkg::CTL_SETUP_OUT]) begin
                        n.setup = 1'b0;
                    end
                    if (wd[sar_pkg::CTL_BERR_ON]) begin
                        n.berr_on = 1'b1;
                    end
                    if (wd[sar_pkg::CTL_BERR_OFF]) begin
                        n.berr_on = 1'b0;
                    end
                end else if (b.cfg_addr == sar_pkg::CONFIG_OFF) begin
                    n.key = wd[sar_pkg::CFG_KEY_LSB +: sar_pkg::KEY_W];
                    n.cyc = wd[sar_pkg::CFG_CYC_LSB +: sar_pkg::CYC_W];
                    n.open = wd[sar_pkg::CFG_OPEN_BIT];
                end else if (b.cfg_addr == sar_pkg::CHEN_HI_OFF) begin
                    // top bit would be channel 63, which is the unlock register
                    n.chen[63:32] = {1'b0, wd[30:0]};
                end else if (b.cfg_addr == sar_pkg::CHEN_LO_OFF) begin
                    n.chen[31:0] = wd;
                end else if (b.cfg_addr == sar_pkg::IEN_OFF) begin
                    n.imask = r.imask | wd[sar_pkg::EVT_W-1:0];
                end else if (b.cfg_addr == sar_pkg::IOFF_OFF) begin
                    n.imask = r.imask & ~wd[sar_pkg::EVT_W-1:0];
                end else if (b.cfg_addr == sar_pkg::ICLR_OFF) begin
                    n.evt = r.evt & ~wd[sar_pkg::EVT_W-1:0];
                end
            end else begin
                if (b.cfg_addr == sar_pkg::CHEN_HI_OFF) begin
                    n.cfg_rdata = r.chen[63:32];
                end else if (b.cfg_addr == sar_pkg::CHEN_LO_OFF) begin
                    n.cfg_rdata = r.chen[31:0];
                end else if (b.cfg_addr == sar_pkg::STATUS_OFF) begin
                    n.cfg_rdata = {21'h000000, r.state == sar_pkg::DEV_IDLE,
                        r.setup, r.on, r.evt};
                end else if (b.cfg_addr == sar_pkg::IMASK_OFF) begin
                    n.cfg_rdata = {24'h000000, r.imask};
                end
            end
        end
        // ==========================================================
        // channel space slave port
        if (r.state == sar_pkg::DEV_IDLE && b.hs_req && !r.hs_done) begin
            if (ch == sar_pkg::UNLK_IDX) begin
                n.hs_done = 1'b1;
                if (!b.hs_wr) begin
                    n.evt[sar_pkg::ST_UNLK_READ] = 1'b1;
                    n.evt[sar_pkg::ST_MBUS_ERR] = 1'b1;
                    n.hs_err = r.berr_on;
                end else if (|(r.evt & sar_pkg::ERR_MASK)) begin
                    n.evt[sar_pkg::ST_UNLK_ERR] = 1'b1;
                end else if (b.hs_wdata[sar_pkg::UNLK_KEY_LSB +: sar_pkg::KEY_W] != r.key) begin
                    n.evt[sar_pkg::ST_KEY_ERR] = 1'b1;
                end else begin
                    // overwriting the channel number relocks the previous one
                    touch = 1'b1;
                    n.unlocked = 1'b1;
                    n.ulch = b.hs_wdata[sar_pkg::UNLK_CH_LSB +: 6];
                    n.timer = r.cyc;
                end
            end else if (r.setup) begin
                n.hs_done = 1'b1;
                n.hs_rdata = 32'h00000000;
                if (b.hs_wr) begin
                    n.remap_target_reg[ch] = b.hs_wdata;
                    if (b.hs_wdata < sar_pkg::REMAP_LOW) begin
                        n.evt[sar_pkg::ST_RTADR_ERR] = 1'b1;
                    end
                end else begin
                    n.hs_rdata = tgt;
                end
            end else if (permit) begin
                // the one access consumes the unlock window
                touch = 1'b1;
                n.unlocked = 1'b0;
                n.state = sar_pkg::DEV_MASTER;
                n.m_req = 1'b1;
                n.m_wr = b.hs_wr;
                n.m_addr = tgt;
                n.m_wdata = b.hs_wdata;
            end else begin
                n.hs_done = 1'b1;
                n.hs_rdata = 32'h00000000;
                n.evt[sar_pkg::ST_ACC_FAIL] = 1'b1;
                n.evt[sar_pkg::ST_MBUS_ERR] = 1'b1;
                n.hs_err = r.berr_on;
            end
        end
        // ==========================================================
        // master port completion
        if (r.state == sar_pkg::DEV_MASTER && b.m_done) begin
            n.state = sar_pkg::DEV_IDLE;
            n.m_req = 1'b0;
            n.hs_done = 1'b1;
            n.hs_rdata = b.m_rdata;
            if (b.m_err) begin
                n.evt[sar_pkg::ST_MBUS_ERR] = 1'b1;
                n.hs_err = r.berr_on;
            end else begin
                n.evt[sar_pkg::ST_ACC_OK] = 1'b1;
            end
        end
        // ==========================================================
        // unlock window; counts cyc cycles, skipped when unlock or access lands
        if (r.unlocked && !touch) begin
            if (r.timer == '0) begin
                n.unlocked = 1'b0;
                n.evt[sar_pkg::ST_EXPIRED] = 1'b1;
            end else begin
                n.timer = r.timer - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.state <= sar_pkg::DEV_IDLE;
        end else if (ce) begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    assign b.cfg_rdata = r.cfg_rdata;
    assign b.cfg_done = r.cfg_done;
    assign b.hs_rdata = r.hs_rdata;
    assign b.hs_done = r.hs_done;
    assign b.hs_err = r.hs_err;
    assign b.m_req = r.m_req;
    assign b.m_wr = r.m_wr;
    assign b.m_addr = r.m_addr;
    assign b.m_wdata = r.m_wdata;
    assign b.irq = |(r.evt & r.imask);
endmodule : sar_device
`default_nettype wire

// ==== design/sar_host.sv ====
// cpu side: axi4-lite command registers driving the unit, plus remapped peripheral
`timescale 1ns/10ps
`default_nettype none
module sar_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    sar_if.host_mp b
);
    // ==========================================================
    // state
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] cmd_addr;
        logic cmd_fast;
        logic cmd_wr;
        logic [31:0] cmd_wdata;
        logic busy;
        logic err;
        logic [31:0] result;
    } sar_host_s;
    sar_host_s r;
    sar_host_s n;
    logic done;

    // strobes ignored: every register is written as a whole word
    assign done = r.cmd_fast ? b.hs_done : b.cfg_done;

    always_comb begin
        n = r;
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = sar_pkg::RESP_OKAY;
            // a new command while one runs is dropped
            if (r.aw_addr == sar_pkg::HOST_CMD_OFF) begin
                if (!r.busy) begin
                    n.busy = 1'b1;
                    n.cmd_addr = r.w_data[7:0];
                    n.cmd_fast = r.w_data[sar_pkg::CMD_FAST_BIT];
                    n.cmd_wr = r.w_data[sar_pkg::CMD_WR_BIT];
                end
            end else if (r.aw_addr == sar_pkg::HOST_WDATA_OFF) begin
                n.cmd_wdata = r.w_data;
            end else begin
                n.bresp = sar_pkg::RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp = sar_pkg::RESP_OKAY;
            n.rdata = 32'h00000000;
            if (s_axi_araddr == sar_pkg::HOST_WDATA_OFF) begin
                n.rdata = r.cmd_wdata;
            end else if (s_axi_araddr == sar_pkg::HOST_RDATA_OFF) begin
                n.rdata = r.result;
            end else if (s_axi_araddr == sar_pkg::HOST_STAT_OFF) begin
                n.rdata = {29'h00000000, b.irq, r.err, r.busy};
            end else if (s_axi_araddr != sar_pkg::HOST_CMD_OFF) begin
                n.rresp = sar_pkg::RESP_SLVERR;
            end
        end
        // busy clears on the done of the port in use; err keeps only the channel port's bus error
        if (r.busy && done) begin
            n.busy = 1'b0;
            n.result = r.cmd_fast ? b.hs_rdata : b.cfg_rdata;
            n.err = r.cmd_fast & b.hs_err;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready = !r.w_got && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    // software sequences key, window, unlock and access through these commands
    assign b.cfg_req = r.busy && !r.cmd_fast;
    assign b.cfg_wr = r.cmd_wr;
    assign b.cfg_addr = r.cmd_addr[5:0];
    assign b.cfg_wdata = r.cmd_wdata;
    assign b.hs_req = r.busy && r.cmd_fast;
    assign b.hs_wr = r.cmd_wr;
    assign b.hs_addr = r.cmd_addr;
    assign b.hs_wdata = r.cmd_wdata;

    sar_target u_target (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .req(b.m_req),
        .wr(b.m_wr),
        .addr(b.m_addr),
        .wdata(b.m_wdata),
        .rdata(b.m_rdata),
        .done(b.m_done),
        .err(b.m_err)
    );
endmodule : sar_host
`default_nettype wire

// ==== tb/sar_props.sv ====
// concurrent checks on the link between the unit and its host
`timescale 1ns/10ps
`default_nettype none
module sar_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cfg_req,
    input wire logic cfg_done,
    input wire logic hs_req,
    input wire logic [7:0] hs_addr,
    input wire logic hs_done,
    input wire logic hs_err,
    input wire logic m_req,
    input wire logic [31:0] m_addr,
    input wire logic m_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // link relations; ce is tied high by the bench, so no stall terms
    a_cfg_answer: assert property (cfg_req && !cfg_done |=> cfg_done)
        else $error("config request not answered");
    a_low_target: assert property (m_req |-> m_addr >= sar_pkg::REMAP_LOW)
        else $error("remap below region");
    a_master_hold: assert property (m_req && !m_done |=> m_req && $stable(m_addr))
        else $error("master request dropped");
    a_master_ends: assert property (m_done |=> hs_done && !m_req)
        else $error("no reply after master");
    a_unlock_fast: assert property ($rose(hs_req) && hs_addr[7:2] == 6'h3F |=> hs_done && !m_req)
        else $error("unlock write not single cycle");
    a_done_pulse: assert property (hs_done |=> !hs_done)
        else $error("channel done too long");
    a_err_with_done: assert property (hs_err |-> hs_done)
        else $error("bus error without done");
    a_master_cause: assert property ($rose(m_req) |-> $past(hs_req) && hs_addr[7:2] != 6'h3F)
        else $error("master request without cause");
    c_unlock: cover property (hs_done && hs_addr == 8'hFC);
    c_remap: cover property (m_done);
    c_berr: cover property (hs_err);
endmodule : sar_props
`default_nettype wire

// ==== tb/tb_secure_access_remap_channels.sv ====
// testbench: axi4-lite orders through the host into the unit
`timescale 1ns/10ps
`default_nettype none
module tb_secure_access_remap_channels;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, v, rnd = 32'h4A;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_q[$], msk_q[$];
    string nm_q[$];
    logic [7:0] ch [3] = '{8'h00, 8'h04, 8'h84};
    int failures = 0, num_checks = 0, cyc = 0;
    sar_if b ();
    sar_device i_sar_device (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .b(b.dev_mp));
    sar_host i_sar_host (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .b(b.host_mp));
    sar_props i_sar_props (.aclk(aclk), .aresetn(aresetn), .cfg_req(b.cfg_req),
        .cfg_done(b.cfg_done), .hs_req(b.hs_req), .hs_addr(b.hs_addr), .hs_done(b.hs_done),
        .hs_err(b.hs_err), .m_req(b.m_req), .m_addr(b.m_addr), .m_done(b.m_done));
    always #2.5 aclk = ~aclk;
    // ==========
    // bus tasks; ready is sampled at the falling edge so the rising edge never races
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report;
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awready && awvalid;
            tw = wready && wvalid;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask : axw
    task automatic axr(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m, input logic [1:0] rs);
        logic ta, tr;
        nm_q.push_back(nm);
        msk_q.push_back({2'h3, m});
        exp_q.push_back({rs, e & m});
        araddr <= a;
        arvalid <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arready && arvalid;
            tr = rvalid;
            v = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
    endtask : axr
    // one order to the unit, then wait until the host is no longer busy
    task automatic op(input logic [9:0] c, input logic [31:0] d);
        axw(8'h04, d);
        axw(8'h00, {22'h0, c});
        v = 32'h1;
        while (v[0]) axr("busy", 8'h0C, 32'h0, 32'h0, 2'h0);
    endtask : op
    task automatic cw(input logic [5:0] o, input logic [31:0] d);
        op({4'h8, o}, d);
    endtask : cw
    task automatic st(input logic [31:0] e, input logic [31:0] m);
        op({4'h0, 6'h10}, 32'h0);
        axr("status", 8'h08, e, m, 2'h0);
    endtask : st
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d, input logic be);
        op({w, 1'b1, a}, d);
        axr("bus error", 8'h0C, {30'h0, be, 1'b0}, 32'h2, 2'h0);
        if (!w && !be) axr("read data", 8'h08, d, 32'hFFFFFFFF, 2'h0);
    endtask : acc
    always @(negedge aclk) begin
        if (rvalid) chk(nm_q.pop_front(), {rresp, rdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            final_report();
        end
    end
    // ==========
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        st(32'h400, 32'hFFFFFFFF);
        axr("unmapped", 8'h40, 32'h0, 32'h0, sar_pkg::RESP_SLVERR);
        cw(6'h00, 32'h11);
        st(32'h500, 32'hFFFFFFFF);
        cw(6'h00, 32'h4);
        st(32'h200, 32'h200);
        acc(8'h00, 1'b1, 32'hFFFC0000, 1'b0);
        acc(8'h04, 1'b1, 32'hFFFC0004, 1'b0);
        acc(8'h84, 1'b1, 32'hFFFC0008, 1'b0);
        acc(8'h04, 1'b0, 32'hFFFC0004, 1'b0);
        acc(8'h08, 1'b1, 32'h00001000, 1'b0);
        st(32'h80, 32'h80);
        cw(6'h20, 32'hFF);
        cw(6'h00, 32'h8);
        st(32'h500, 32'hFFFFFFFF);
        cw(6'h04, 32'h10000);
        acc(8'h00, 1'b1, rnd, 1'b1);
        st(32'h42, 32'h42);
        cw(6'h20, 32'hFF);
        cw(6'h0C, 32'h7);
        cw(6'h08, 32'h2);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            acc(ch[i], 1'b1, rnd, 1'b0);
            acc(ch[i], 1'b0, rnd, 1'b0);
        end
        st(32'h501, 32'hFFFFFFFF);
        acc(8'h08, 1'b0, 32'h0, 1'b1);
        cw(6'h20, 32'hFF);
        // key 5A, window of 128 cycles, locked mode
        cw(6'h04, 32'h805A);
        acc(8'h00, 1'b0, 32'h0, 1'b1);
        cw(6'h20, 32'hFF);
        acc(8'hFC, 1'b1, 32'hA5, 1'b0);
        st(32'h10, 32'h10);
        acc(8'h00, 1'b0, 32'h0, 1'b1);
        cw(6'h20, 32'hFF);
        acc(8'hFC, 1'b1, 32'h5A, 1'b0);
        rnd = lfsr(rnd);
        acc(8'h00, 1'b1, rnd, 1'b0);
        acc(8'h00, 1'b0, rnd, 1'b1);
        cw(6'h14, 32'h2);
        axr("irq", 8'h0C, 32'h4, 32'h4, 2'h0);
        cw(6'h18, 32'h2);
        axr("irq", 8'h0C, 32'h0, 32'h4, 2'h0);
        cw(6'h14, 32'h2);
        acc(8'hFC, 1'b1, 32'h15A, 1'b0);
        st(32'h20, 32'h20);
        acc(8'h04, 1'b0, 32'h0, 1'b1);
        cw(6'h20, 32'hFF);
        axr("irq", 8'h0C, 32'h0, 32'h4, 2'h0);
        acc(8'hFC, 1'b1, 32'h5A, 1'b0);
        acc(8'hFC, 1'b1, 32'h15A, 1'b0);
        acc(8'h00, 1'b0, 32'h0, 1'b1);
        cw(6'h20, 32'hFF);
        acc(8'hFC, 1'b1, 32'h5A, 1'b0);
        repeat (200) @(posedge aclk);
        st(32'h4, 32'h4);
        cw(6'h20, 32'hFF);
        acc(8'hFC, 1'b0, 32'h0, 1'b1);
        st(32'h48, 32'h48);
        cw(6'h20, 32'hFF);
        cw(6'h00, 32'h20);
        acc(8'h00, 1'b0, 32'h0, 1'b0);
        st(32'h42, 32'h42);
        cw(6'h20, 32'hFF);
        cw(6'h00, 32'h2);
        st(32'h400, 32'hFFFFFFFF);
        final_report();
    end
endmodule : tb_secure_access_remap_channels
`default_nettype wire
